// >>> verilog/drq_engine.sv
// Device-side descriptor ring queue engine: fetch, chain walk, used post, interrupts
`timescale 1ns/1ps
// What the document requires
// RULE_01 - Accept config writes before feature negotiation
// RULE_02 - Allow queue use before driver ready; the engine allows it only in legacy_mode
// RULE_03 - Legacy driver skips features-accepted steps
// RULE_04 - Buffer: readable then writable elements
// RULE_05 - Descriptor holds address, length, writable flag
// RULE_06 - Chain via next index and continue flag
// RULE_07 - Head goes at index plus added, modulo size
// RULE_08 - Driver advances index by heads added
// RULE_09 - Pending count uses modulo 65536 arithmetic
// RULE_10 - Queue size at most 32768, power two
// RULE_11 - Driver writes ring before index update
// RULE_12 - Fetch as soon as index advances
// RULE_13 - Driver notifies unless suppressed
// RULE_14 - Driver orders index update before flag read
// RULE_15 - Device may suppress driver notifications
// RULE_16 - Interrupt driver after consuming buffers
// RULE_17 - Config change raises config interrupt
// RULE_18 - Needs-reset bit raises config interrupt
// RULE_19 - Queues live once driver ready set
// RULE_20 - Device reset makes all queues non-live
// RULE_21 - Driver keeps exposed descriptors unchanged
// RULE_22 - Driver never decrements available index
// RULE_23 - Interrupt only when driver flags zero
// RULE_24 - Driver notifies when device flags zero
// RULE_25 - Private last-seen index, advanced modulo 65536
module drq_engine (
  input  wire logic                        clock,          // 40 MHz clock
  input  wire logic                        nrst,           // Async reset, active low
  input  wire logic                        dev_reset,      // Driver-requested device reset
  input  wire logic                        legacy_mode,    // Legacy interface in use
  input  wire logic [drq_pkg::STAT_W-1:0]  dev_status,     // Device status byte from driver
  input  wire logic [drq_pkg::MEM_AW-1:0]  queue_sel,      // Queue being serviced
  input  wire logic [drq_pkg::QSZ_W-1:0]   queue_size,     // Configured queue size
  input  wire logic                        queue_enable,   // Queue configured by driver
  input  wire logic [drq_pkg::IDX_W-1:0]   avail_idx,      // Published available index
  input  wire logic [drq_pkg::FLG_W-1:0]   avail_flags,    // Driver interrupt suppression
  input  wire logic                        want_quiet,     // Device needs no notifications
  input  wire logic                        cfg_wr,         // Driver config field write
  input  wire logic                        cfg_changed,    // Device config changed, pulse
  input  wire logic                        need_reset_req, // Device wants reset, pulse
  output logic                             cfg_wr_ok,      // Config write accepted
  output logic                             ring_rd,        // Ring entry read request
  output logic      [drq_pkg::IDX_W-1:0]   ring_slot,      // Ring slot to read
  input  wire logic                        ring_vld,       // Ring entry returned
  input  wire logic [drq_pkg::IDX_W-1:0]   ring_head,      // Chain head from ring
  output logic                             desc_rd,        // Descriptor read request
  output logic      [drq_pkg::IDX_W-1:0]   desc_index,     // Descriptor to read
  input  wire logic                        desc_vld,       // Descriptor returned
  input  wire logic [drq_pkg::ADDR_W-1:0]  desc_addr,      // Element start address
  input  wire logic [drq_pkg::LEN_W-1:0]   desc_len,       // Element length
  input  wire logic [drq_pkg::FLG_W-1:0]   desc_flags,     // Element flags
  input  wire logic [drq_pkg::IDX_W-1:0]   desc_next,      // Next descriptor index
  output logic                             elem_vld,       // Element handed to datapath
  output logic      [drq_pkg::ADDR_W-1:0]  elem_addr,      // Element address
  output logic      [drq_pkg::LEN_W-1:0]   elem_len,       // Element length
  output logic                             elem_wr,        // Element device-writable
  input  wire logic                        elem_done,      // Datapath finished element
  input  wire logic [drq_pkg::LEN_W-1:0]   elem_written,   // Bytes written into element
  output logic                             used_wr,        // Post used entry, pulse
  output logic      [drq_pkg::IDX_W-1:0]   used_id,        // Chain head consumed
  output logic      [drq_pkg::LEN_W-1:0]   used_len,       // Total bytes written
  output logic      [drq_pkg::FLG_W-1:0]   used_flags,     // Device notify suppression
  output logic                             queue_live,     // Queue is live
  output logic                             vq_irq,         // Used-buffer interrupt, pulse
  output logic                             cfg_irq,        // Config-change interrupt, pulse
  output logic                             need_reset_bit, // Needs-reset status bit
  output logic                             size_bad        // Queue size illegal
);
  drq_pkg::drq_state_e st_r, st_nxt;
  logic [drq_pkg::IDX_W-1:0]  last_seen;
  logic [drq_pkg::IDX_W-1:0]  pending;
  logic [drq_pkg::IDX_W-1:0]  size_mask;
  logic [drq_pkg::IDX_W-1:0]  head_r;
  logic [drq_pkg::IDX_W-1:0]  next_r;
  logic [drq_pkg::LEN_W-1:0]  total_r;
  logic                       cont_r;
  logic                       live_r;
  logic                       nrb_r;
  logic                       size_ok;
  logic                       may_run;
  logic                       seen_we;
  logic                       mem_clr;
  logic                       irq_want;
  logic                       rd_seen_r;

  // Power of two and no larger than the ceiling keeps full and empty apart
  assign size_ok   = (queue_size != '0) && (queue_size <= drq_pkg::QSZ_MAX_C)
                     && ((queue_size & (queue_size - 16'h0001)) == '0); // RULE_10
  assign size_mask = queue_size - 16'h0001;
  assign size_bad  = queue_enable && !size_ok;

  // Legacy drivers may run queues before driver-ready
  assign may_run   = queue_enable && size_ok && (live_r || legacy_mode); // RULE_02
  // Unsigned subtraction wraps, so a wrapped index still gives the right count
  assign pending   = avail_idx - last_seen; // RULE_09
  // Config writes are never gated by negotiation progress
  assign cfg_wr_ok = cfg_wr; // RULE_01
  assign mem_clr   = dev_reset;
  assign seen_we   = (st_r == drq_pkg::DRQ_USED);
  // Driver flag value 1 suppresses, 0 demands an interrupt
  assign irq_want  = (avail_flags[drq_pkg::SUP_BIT] == 1'b0); // RULE_23

  drq_mem u_seen (
    .clock (clock),
    .nrst  (nrst),
    .we    (seen_we),
    .waddr (queue_sel),
    .wdata (last_seen + 16'h0001), // RULE_25
    .clr   (mem_clr),
    .raddr (queue_sel),
    .rdata (last_seen)
  );

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      drq_pkg::DRQ_IDLE:
        if (may_run && pending != '0 && rd_seen_r)
          st_nxt = drq_pkg::DRQ_RING; // RULE_12
      drq_pkg::DRQ_RING:
        if (ring_vld)
          st_nxt = drq_pkg::DRQ_DESC;
      drq_pkg::DRQ_DESC:
        if (desc_vld)
          st_nxt = drq_pkg::DRQ_WORK;
      drq_pkg::DRQ_WORK:
        if (elem_done)
          st_nxt = cont_r ? drq_pkg::DRQ_DESC : drq_pkg::DRQ_USED; // RULE_06
      drq_pkg::DRQ_USED:
        st_nxt = drq_pkg::DRQ_NOTE;
      drq_pkg::DRQ_NOTE:
        st_nxt = drq_pkg::DRQ_IDLE;
      default:
        st_nxt = drq_pkg::DRQ_IDLE;
    endcase
    if (dev_reset)
      st_nxt = drq_pkg::DRQ_IDLE;
  end

  assign ring_rd    = (st_r == drq_pkg::DRQ_RING);
  assign ring_slot  = last_seen & size_mask; // RULE_07
  assign desc_rd    = (st_r == drq_pkg::DRQ_DESC);
  assign desc_index = next_r;
  assign queue_live = live_r;
  assign need_reset_bit = nrb_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      st_r <= drq_pkg::DRQ_IDLE;
    else
      st_r <= st_nxt;
  end

  // Memory read lags a clear or write by a cycle; a stale index would fetch the wrong slot
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rd_seen_r <= 1'b1;
    else
      rd_seen_r <= !(mem_clr || seen_we);
  end

  // Reset clears liveness; driver-ready makes the configured queue live
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      live_r <= 1'b0;
    else if (dev_reset)
      live_r <= 1'b0; // RULE_20
    else
      live_r <= dev_status[drq_pkg::STAT_DRV_OK] && queue_enable; // RULE_19
  end

  // Set wins over the driver's reset that clears it
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      nrb_r <= 1'b0;
    else if (need_reset_req)
      nrb_r <= 1'b1;
    else if (dev_reset)
      nrb_r <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cfg_irq <= 1'b0;
    else
      cfg_irq <= cfg_changed || (need_reset_req && !nrb_r); // RULE_17 RULE_18
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      head_r  <= '0;
      next_r  <= '0;
      cont_r  <= 1'b0;
      total_r <= '0;
    end
    else if (st_r == drq_pkg::DRQ_RING && ring_vld)
    begin
      head_r  <= ring_head;
      next_r  <= ring_head;
      total_r <= '0;
    end
    else if (st_r == drq_pkg::DRQ_DESC && desc_vld)
    begin
      cont_r <= desc_flags[drq_pkg::FLG_CONTINUE];
      next_r <= desc_next;
    end
    else if (st_r == drq_pkg::DRQ_WORK && elem_done)
      total_r <= total_r + elem_written;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      elem_vld  <= 1'b0;
      elem_addr <= '0;
      elem_len  <= '0;
      elem_wr   <= 1'b0;
    end
    else if (st_r == drq_pkg::DRQ_DESC && desc_vld && !dev_reset)
    begin
      elem_vld  <= 1'b1;
      elem_addr <= desc_addr;
      elem_len  <= desc_len;
      elem_wr   <= desc_flags[drq_pkg::FLG_WRITABLE];
    end
    else if (elem_done || dev_reset)
      elem_vld  <= 1'b0;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      used_wr    <= 1'b0;
      used_id    <= '0;
      used_len   <= '0;
      used_flags <= '0;
      vq_irq     <= 1'b0;
    end
    else
    begin
      used_wr    <= seen_we;
      used_flags <= {15'h0000, want_quiet}; // RULE_15
      if (seen_we)
      begin
        used_id  <= head_r;
        used_len <= total_r;
      end
      // Raised one cycle after the used entry so it lands after the post
      vq_irq     <= (st_r == drq_pkg::DRQ_NOTE) && irq_want; // RULE_16
    end
  end
endmodule

// >>> verilog/drq_pkg.sv
// Constants and types shared by the descriptor ring queue engine
package drq_pkg;
  localparam int unsigned IDX_W        = 16;
  localparam int unsigned ADDR_W       = 64;
  localparam int unsigned LEN_W        = 32;
  localparam int unsigned QSZ_MAX      = 32768;
  localparam int unsigned QSZ_W        = 16;
  localparam logic [15:0] QSZ_MAX_C    = 16'h8000;
  localparam logic [15:0] IDX_RST      = 16'h0000;
  localparam int unsigned FLG_W        = 16;
  localparam int unsigned FLG_WRITABLE = 1;
  localparam int unsigned FLG_CONTINUE = 0;
  localparam int unsigned STAT_W       = 8;
  localparam int unsigned STAT_DRV_OK  = 2;
  localparam int unsigned STAT_NEEDRST = 6;
  localparam int unsigned SUP_BIT      = 0;
  localparam int unsigned MEM_AW       = 4;
  localparam int unsigned MEM_DW       = 16;

  typedef enum logic [2:0] {
    DRQ_IDLE  = 3'b000,
    DRQ_RING  = 3'b001,
    DRQ_DESC  = 3'b010,
    DRQ_WORK  = 3'b011,
    DRQ_USED  = 3'b100,
    DRQ_NOTE  = 3'b101
  } drq_state_e;
endpackage

// >>> verilog/drq_mem.sv
// Small register-file memory holding the per-queue last-seen available index
`timescale 1ns/1ps
module drq_mem (
  input  wire logic                       clock,  // System clock
  input  wire logic                       nrst,   // Async reset, active low
  input  wire logic                       we,     // Write enable
  input  wire logic [drq_pkg::MEM_AW-1:0] waddr,  // Write address
  input  wire logic [drq_pkg::MEM_DW-1:0] wdata,  // Write data
  input  wire logic                       clr,    // Clear all words
  input  wire logic [drq_pkg::MEM_AW-1:0] raddr,  // Read address
  output logic      [drq_pkg::MEM_DW-1:0] rdata   // Registered read data
);
  localparam int unsigned DEPTH = 1 << drq_pkg::MEM_AW;
  localparam int unsigned AW    = drq_pkg::MEM_AW;
  logic [drq_pkg::MEM_DW-1:0] mem_r [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_word
      always_ff @(posedge clock or negedge nrst)
      begin
        if (!nrst)
          mem_r[g] <= drq_pkg::IDX_RST;
        else if (clr)
          mem_r[g] <= drq_pkg::IDX_RST;
        else if (we && waddr == AW'(g))
          mem_r[g] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata <= '0;
    else
      rdata <= mem_r[raddr];
  end
endmodule

// >>> verif/drq_props.sv
// Assertions on the queue engine ports
`timescale 1ns/1ps
module drq_props (
  input wire logic        clock,          // Clock
  input wire logic        nrst,           // Reset
  input wire logic        dev_reset,      // Dev reset
  input wire logic        legacy_mode,    // Legacy
  input wire logic [7:0]  dev_status,     // Status
  input wire logic [15:0] queue_size,     // Size
  input wire logic        queue_enable,   // Enable
  input wire logic [15:0] avail_flags,    // Irq mask
  input wire logic        cfg_changed,    // Change
  input wire logic        need_reset_req, // Req
  input wire logic        ring_rd,        // Fetch
  input wire logic        used_wr,        // Post
  input wire logic        queue_live,     // Live
  input wire logic        vq_irq,         // Irq
  input wire logic        cfg_irq,        // Cfg irq
  input wire logic        need_reset_bit, // Bit
  input wire logic        size_bad        // Bad size
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  wire size_ok = queue_size != 16'h0 && queue_size <= 16'h8000
    && (queue_size & (queue_size - 16'h1)) == 16'h0;
  sequence s_irq; ##1 vq_irq; endsequence
  property p_size; size_bad == (queue_enable && !size_ok); endproperty
  a_size: assert property (p_size) else $error("size flag wrong");
  // Driver-ready is in the guard since queue_live is registered and lags dev_status by one cycle
  property p_refuse; (size_bad || !(queue_live || dev_status[2] || legacy_mode)) && !ring_rd
    |=> !ring_rd; endproperty
  a_refuse: assert property (p_refuse) else $error("fetch while refused");
  property p_live; dev_status[2] && queue_enable && !dev_reset |=> queue_live; endproperty
  a_live: assert property (p_live) else $error("queue not live");
  property p_dead; dev_reset |=> !queue_live; endproperty
  a_dead: assert property (p_dead) else $error("live after reset");
  property p_irq; used_wr && !avail_flags[0] |-> s_irq; endproperty
  a_irq: assert property (p_irq) else $error("no used irq");
  property p_quiet; used_wr && avail_flags[0] |=> !vq_irq; endproperty
  a_quiet: assert property (p_quiet) else $error("irq while masked");
  property p_cfg; cfg_changed |=> cfg_irq; endproperty
  a_cfg: assert property (p_cfg) else $error("no cfg irq");
  property p_nrb; need_reset_req && !need_reset_bit |=> cfg_irq && need_reset_bit; endproperty
  a_nrb: assert property (p_nrb) else $error("no reset bit irq");
endmodule

// >>> verif/drq_host.sv
// Host memory model: ring, descriptor table and element datapath
`timescale 1ns/1ps
module drq_host (
  input  wire logic        clock,        // Clock
  input  wire logic [3:0]  lat,          // Wait cycles
  input  wire logic        ring_rd,      // Ring read
  input  wire logic [15:0] ring_slot,    // Slot
  input  wire logic        desc_rd,      // Desc read
  input  wire logic [15:0] desc_index,   // Index
  input  wire logic        elem_vld,     // Element
  input  wire logic        elem_wr,      // Writable
  output logic             ring_vld,     // Ring answer
  output logic      [15:0] ring_head,    // Head
  output logic             desc_vld,     // Desc answer
  output logic      [63:0] desc_addr,    // Address
  output logic      [31:0] desc_len,     // Length
  output logic      [15:0] desc_flags,   // Flags
  output logic      [15:0] desc_next,    // Next
  output logic             elem_done,    // Done
  output logic      [31:0] elem_written  // Written
);
  logic [3:0] w = 4'h0;
  wire busy = (ring_rd || desc_rd || elem_vld) && !(ring_vld || desc_vld || elem_done);
  initial {ring_vld, ring_head, desc_vld, desc_addr, desc_len, desc_flags, desc_next} = '0;
  initial {elem_done, elem_written} = '0;
  always @(negedge clock)
  begin
    w <= (busy && w != lat) ? w + 4'h1 : 4'h0;
    if (busy && w == lat)
    begin
      ring_vld <= ring_rd;
      ring_head <= {ring_slot[14:0], 1'b0};
      desc_vld <= desc_rd;
      desc_addr <= {40'h0, desc_index, 8'h00};
      desc_len <= {16'h0, desc_index} + 32'h10;
      desc_flags <= {14'h0, desc_index[0], ~desc_index[0]};
      desc_next <= desc_index + 16'h1;
      elem_done <= elem_vld;
      elem_written <= elem_wr ? 32'h4 : 32'h0;
    end
    else
    begin
      // Valid lines drop and data lines flip each cycle so stale data is never mistaken for an answer
      {ring_vld, desc_vld, elem_done} <= 3'b0;
      {ring_head, desc_flags, desc_next} <= ~{ring_head, desc_flags, desc_next};
      {desc_addr, desc_len, elem_written} <= ~{desc_addr, desc_len, elem_written};
    end
  end
endmodule

// >>> verif/drq_engine_tb.sv
// Self-checking bench for the descriptor ring queue engine
`timescale 1ns/1ps
module drq_engine_tb;
  logic        clock, nrst, dev_reset, legacy_mode, queue_enable, want_quiet, cfg_wr;
  logic        cfg_changed, need_reset_req, cfg_wr_ok, ring_rd, ring_vld, desc_rd, desc_vld;
  logic        elem_vld, elem_wr, elem_done, used_wr, queue_live, vq_irq, cfg_irq;
  logic        need_reset_bit, size_bad;
  logic [3:0]  queue_sel, lat;
  logic [7:0]  dev_status;
  logic [15:0] queue_size, avail_idx, avail_flags, ring_slot, ring_head, desc_index;
  logic [15:0] desc_flags, desc_next, used_id, used_flags, seen;
  logic [31:0] desc_len, elem_len, elem_written, used_len;
  logic [63:0] desc_addr, elem_addr;
  int          n_fail = 0, compares = 0, n_used = 0, n_irq = 0, n_cfg = 0;
  wire [15:0]  slot_x = seen & (queue_size - 16'h1);
  drq_engine dut (.clock, .nrst, .dev_reset, .legacy_mode, .dev_status, .queue_sel, .queue_size,
    .queue_enable, .avail_idx, .avail_flags, .want_quiet, .cfg_wr, .cfg_changed, .need_reset_req,
    .cfg_wr_ok, .ring_rd, .ring_slot, .ring_vld, .ring_head, .desc_rd, .desc_index, .desc_vld,
    .desc_addr, .desc_len, .desc_flags, .desc_next, .elem_vld, .elem_addr, .elem_len, .elem_wr,
    .elem_done, .elem_written, .used_wr, .used_id, .used_len, .used_flags, .queue_live, .vq_irq,
    .cfg_irq, .need_reset_bit, .size_bad);
  drq_host host (.clock, .lat, .ring_rd, .ring_slot, .desc_rd, .desc_index, .elem_vld, .elem_wr,
    .ring_vld, .ring_head, .desc_vld, .desc_addr, .desc_len, .desc_flags, .desc_next, .elem_done,
    .elem_written);
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(negedge clock)
  begin
    if (ring_rd)
      chk("ring_slot", seen & (queue_size - 16'h1), ring_slot);
    if (desc_rd)
      chk("desc_index", {17'h0, slot_x[14:0]}, {17'h0, desc_index[15:1]});
    if (elem_vld)
    begin
      chk("elem_addr", {17'h0, slot_x[14:0]}, elem_addr[40:9]);
      chk("elem_len", {16'h0, elem_addr[23:8]} + 32'h10, elem_len);
      chk("elem_wr", {31'h0, elem_addr[8]}, {31'h0, elem_wr});
    end
    if (used_wr)
    begin
      chk("used_id", {seen & (queue_size - 16'h1), 1'b0}, used_id);
      chk("used_len", 32'h4, used_len);
      n_used++;
      seen++;
    end
    if (vq_irq)
      n_irq++;
    if (cfg_irq)
      n_cfg++;
  end
  task automatic wait_used(input int n);
    int k;
    int goal;
    goal = n_used + n;
    for (k = 0; k < 300 && n_used < goal; k++) @(negedge clock);
    chk("used count", goal, n_used);
    if (n_used < goal) finish_test();
    repeat (4) @(negedge clock);
  endtask
  task automatic t_idle;
    chk("outs", 32'h0, {queue_live, need_reset_bit, cfg_irq, vq_irq, used_wr});
    cfg_wr = 1'b1;
    #1 chk("cfg_wr_ok", 32'h1, cfg_wr_ok);
    @(negedge clock) cfg_wr = 1'b0;
    avail_idx = 16'h3;
    repeat (20) @(negedge clock);
    chk("used early", 32'h0, n_used);
  endtask
  task automatic t_live;
    dev_status = 8'h04;
    @(negedge clock);
    chk("notify", 32'h1, {31'h0, !used_flags[0]});
    wait_used(3);
    chk("queue_live", 32'h1, queue_live);
    chk("irqs", 32'h3, n_irq);
  endtask
  task automatic t_quiet;
    {avail_flags, want_quiet, lat} = {16'h1, 1'b1, 4'h3};
    avail_idx += 16'h2;
    @(negedge clock);
    chk("notify", 32'h0, {31'h0, !used_flags[0]});
    wait_used(2);
    chk("irqs", 32'h3, n_irq);
    chk("used_flags", 32'h1, used_flags);
    {avail_flags, want_quiet, lat} = '0;
  endtask
  task automatic t_cfg;
    cfg_changed = 1'b1;
    @(negedge clock) cfg_changed = 1'b0;
    need_reset_req = 1'b1;
    @(negedge clock) need_reset_req = 1'b0;
    repeat (3) @(negedge clock);
    chk("cfg irqs", 32'h2, n_cfg);
    chk("need_reset_bit", 32'h1, need_reset_bit);
    {dev_reset, dev_status} = {1'b1, 8'h00};
    @(negedge clock) dev_reset = 1'b0;
    {avail_idx, seen} = '0;
    @(negedge clock);
    chk("live, bit", 32'h0, {queue_live, need_reset_bit});
  endtask
  task automatic t_legacy;
    legacy_mode = 1'b1;
    avail_idx = 16'h1;
    wait_used(1);
    chk("queue_live", 32'h0, queue_live);
    queue_size = 16'h3;
    avail_idx = 16'h2;
    repeat (10) @(negedge clock);
    chk("size_bad", 32'h1, size_bad);
    chk("used total", 32'h6, n_used);
    queue_size = 16'h8000;
    wait_used(1);
    {queue_sel, seen} = {4'h1, 16'h0};
    wait_used(2);
  endtask
  initial
  begin
    {nrst, dev_reset, legacy_mode, dev_status, queue_sel, queue_enable, avail_idx} = '0;
    {avail_flags, want_quiet, cfg_wr, cfg_changed, need_reset_req, lat, seen} = '0;
    {queue_size, queue_enable} = {16'h4, 1'b1};
    repeat (20) @(negedge clock);
    nrst = 1'b1;
    repeat (2) @(negedge clock);
    t_idle();
    t_live();
    t_quiet();
    t_cfg();
    t_legacy();
    finish_test();
  end
endmodule
bind drq_engine drq_props u_p (.clock, .nrst, .dev_reset, .legacy_mode, .dev_status, .queue_size,
  .queue_enable, .avail_flags, .cfg_changed, .need_reset_req, .ring_rd, .used_wr, .queue_live,
  .vq_irq, .cfg_irq, .need_reset_bit, .size_bad);
